// file: src/mom_defs.vh
// constants for the motor over-temperature monitor
// assumes readings are unsigned degrees celsius from an external digitiser
`ifndef MOM_DEFS_VH
`define MOM_DEFS_VH

`define MOM_TW 8
`define MOM_NCH 3
`define MOM_T_ZERO 8'h00
`define MOM_ALARM_C 8'h5A
`define MOM_ERROR_C 8'h78
`define MOM_RESET_C 8'h50
`define MOM_BLINK_W 26
// half period of green blink, 0.25 s at 125 MHz
`define MOM_BLINK_HALF 26'h1DCD64F
`define MOM_BLINK_ZERO 26'h0000000
// one-hot states
`define MOM_S_INIT 5'h01
`define MOM_S_NORM 5'h02
`define MOM_S_ALRM 5'h04
`define MOM_S_ERR 5'h08
`define MOM_S_DEAD 5'h10

`endif

// file: src/mom_monitor.v
// motor over-temperature monitor: hottest-sensor state machine, relays, led
// assumes readings arrive on clk_in with a one-cycle valid strobe per channel
// assumes fault flags come from logic on clk_in, so no synchronisers here
`timescale 1ns/100ps
`include "mom_defs.vh"

module mom_monitor
(
   input wire clk_in,
   input wire rst_n_in,
   input wire [`MOM_TW*3-1:0] temp_in,
   input wire [2:0] temp_valid_in,
   input wire [2:0] sensor_fault_in,
   input wire internal_fault_in,
   output reg alarm_relay_closed_out,
   output reg error_relay_closed_out,
   output reg led_green_out,
   output reg led_red_out,
   output reg [4:0] state_out
);

   localparam S_INIT = `MOM_S_INIT;
   localparam S_NORM = `MOM_S_NORM;
   localparam S_ALRM = `MOM_S_ALRM;
   localparam S_ERR = `MOM_S_ERR;
   localparam S_DEAD = `MOM_S_DEAD;

   // -----------------------------------------------------------------
   // per-channel reading capture and running maximum
   // -----------------------------------------------------------------
   reg [`MOM_TW-1:0] temp_r [0:2];
   reg [2:0] seen_r;
   wire [`MOM_TW-1:0] run_max [0:3];
   wire [`MOM_TW-1:0] hot;

   // chain starts at the coldest possible reading
   assign run_max[0] = `MOM_T_ZERO;

   genvar g;
   generate
      for (g = 0; g < `MOM_NCH; g = g + 1)
      begin : g_ch
         // a reading holds until its channel strobes again
         always @(posedge clk_in)
         begin
            if (!rst_n_in)
            begin
               temp_r[g] <= `MOM_T_ZERO;
               seen_r[g] <= 1'b0;
            end
            else if (temp_valid_in[g])
            begin
               temp_r[g] <= temp_in[g*`MOM_TW +: `MOM_TW];
               seen_r[g] <= 1'b1;
            end
         end

         // keep the larger of this channel and the channels before it
         assign run_max[g + 1] = (temp_r[g] > run_max[g]) ? temp_r[g] : run_max[g];
      end
   endgenerate

   // -----------------------------------------------------------------
   // hottest reading
   // -----------------------------------------------------------------
   assign hot = run_max[`MOM_NCH];

   // -----------------------------------------------------------------
   // threshold compares on the hottest reading
   // -----------------------------------------------------------------
   wire hot_over_err;
   wire hot_at_alarm;
   wire hot_back_norm;
   wire hot_below_reset;

   assign hot_over_err = (hot > `MOM_ERROR_C);
   assign hot_at_alarm = (hot >= `MOM_ALARM_C);
   assign hot_back_norm = (hot <= `MOM_ALARM_C);
   assign hot_below_reset = (hot < `MOM_RESET_C);

   // -----------------------------------------------------------------
   // fault and sanity qualifiers
   // -----------------------------------------------------------------
   reg [4:0] state_r;
   reg [4:0] state_nxt;
   wire any_fault;
   wire all_seen;
   wire state_onehot;
   wire abnormal;

   // one bad channel is enough, whatever the others read
   assign any_fault = |sensor_fault_in;
   assign all_seen = &seen_r;
   // an upset state register is treated as an internal failure
   assign state_onehot = (state_r == S_INIT) || (state_r == S_NORM) || (state_r == S_ALRM) ||
                         (state_r == S_ERR) || (state_r == S_DEAD);
   assign abnormal = internal_fault_in || !state_onehot;

   // -----------------------------------------------------------------
   // state machine
   // -----------------------------------------------------------------
   // hottest reading at exactly the alarm level flips normal and alarm each cycle
   always @*
   begin
      state_nxt = state_r;
      if (abnormal)
      begin
         state_nxt = S_DEAD;
      end
      else
      begin
         case (state_r)
            S_INIT:
            begin
               if (any_fault)
               begin
                  state_nxt = S_ERR;
               end
               else if (all_seen)
               begin
                  if (hot_over_err)
                  begin
                     state_nxt = S_ERR;
                  end
                  else if (hot_at_alarm)
                  begin
                     state_nxt = S_ALRM;
                  end
                  else
                  begin
                     state_nxt = S_NORM;
                  end
               end
            end
            S_NORM:
            begin
               if (any_fault || hot_over_err)
               begin
                  state_nxt = S_ERR;
               end
               else if (hot_at_alarm)
               begin
                  state_nxt = S_ALRM;
               end
            end
            S_ALRM:
            begin
               if (any_fault || hot_over_err)
               begin
                  state_nxt = S_ERR;
               end
               else if (hot_back_norm)
               begin
                  state_nxt = S_NORM;
               end
            end
            S_ERR:
            begin
               if (!any_fault && all_seen && hot_below_reset)
               begin
                  state_nxt = S_NORM;
               end
            end
            S_DEAD:
            begin
               state_nxt = S_DEAD;
            end
            default:
            begin
               state_nxt = S_DEAD;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // blink timer
   // -----------------------------------------------------------------
   reg [`MOM_BLINK_W-1:0] blink_cnt_r;
   reg blink_r;
   always @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         blink_cnt_r <= `MOM_BLINK_ZERO;
         blink_r <= 1'b0;
      end
      else if (state_r != S_ALRM)
      begin
         blink_cnt_r <= `MOM_BLINK_ZERO;
         blink_r <= 1'b1;
      end
      else if (blink_cnt_r == `MOM_BLINK_HALF)
      begin
         blink_cnt_r <= `MOM_BLINK_ZERO;
         blink_r <= ~blink_r;
      end
      else
         blink_cnt_r <= blink_cnt_r + 26'h0000001;
   end

   // -----------------------------------------------------------------
   // next-state decode for the outputs
   // -----------------------------------------------------------------
   // outputs decode the next state so they move together with state_out
   wire nxt_norm;
   wire nxt_alrm;
   wire nxt_err;

   assign nxt_norm = (state_nxt == S_NORM);
   assign nxt_alrm = (state_nxt == S_ALRM);
   assign nxt_err = (state_nxt == S_ERR);

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         state_r <= S_INIT;
         state_out <= S_INIT;
      end
      else
      begin
         state_r <= state_nxt;
         state_out <= state_nxt;
      end
   end

   // -----------------------------------------------------------------
   // relay commands, 1 = closed
   // -----------------------------------------------------------------
   always @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         alarm_relay_closed_out <= 1'b0;
      end
      else
      begin
         alarm_relay_closed_out <= nxt_norm;
      end
   end

   always @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         error_relay_closed_out <= 1'b0;
      end
      else
      begin
         error_relay_closed_out <= nxt_norm || nxt_alrm;
      end
   end

   // -----------------------------------------------------------------
   // status led
   // -----------------------------------------------------------------
   always @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         led_green_out <= 1'b0;
      end
      else
      begin
         led_green_out <= nxt_norm || (nxt_alrm && blink_r);
      end
   end

   always @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         led_red_out <= 1'b0;
      end
      else
      begin
         led_red_out <= nxt_alrm || nxt_err;
      end
   end

endmodule // mom_monitor

// file: sim/mom_drive_model.sv
// downstream drive model: motor power follows the error relay
// assumes relay levels arrive on the monitor clock
`timescale 1ns/100ps
module mom_drive_model
(
   input wire clk_in,
   input wire error_relay_in,
   output reg motor_power_out
);
   initial motor_power_out = 1'b0;
   always @(posedge clk_in) motor_power_out <= error_relay_in;
endmodule // mom_drive_model

// file: sim/mom_chk_monitor.sv
// assertions on the over-temperature monitor ports
// assumes it is bound onto every mom_monitor
`timescale 1ns/100ps
module mom_chk_monitor
(
   input wire clk_in,
   input wire rst_n_in,
   input wire [2:0] sensor_fault_in,
   input wire internal_fault_in,
   input wire alarm_relay_closed_out,
   input wire error_relay_closed_out,
   input wire led_green_out,
   input wire led_red_out,
   input wire [4:0] state_out
);
   wire [3:0] o = {alarm_relay_closed_out, error_relay_closed_out, led_green_out, led_red_out};
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   norm_out_a: assert property (state_out == 5'h02 |-> o == 4'hE) else $error("normal out");
   alarm_out_a: assert property (state_out == 5'h04 |-> o[3:2] == 2'h1 && o[0]) else $error("alarm out");
   err_out_a: assert property (state_out == 5'h08 |-> o == 4'h1) else $error("error out");
   dead_out_a: assert property (state_out == 5'h10 |-> o == 4'h0) else $error("dead out");
   init_open_a: assert property (state_out == 5'h01 |-> o[3:2] == 2'h0) else $error("init out");
   fault_err_a: assert property (
      |sensor_fault_in && !internal_fault_in && state_out != 5'h10 |=> state_out == 5'h08) else $error("fault");
   intern_dead_a: assert property (internal_fault_in |=> state_out == 5'h10) else $error("dead");
   rst_init_a: assert property (
      disable iff (1'b0) !rst_n_in |=> state_out == 5'h01 && o == 4'h0) else $error("reset");
endmodule // mom_chk_monitor
bind mom_monitor mom_chk_monitor mom_chk_monitor_i (.*);

// file: sim/tb_top.sv
// self-checking bench for the over-temperature monitor
// assumes design, checker and drive model are compiled first
`timescale 1ns/100ps
`include "mom_defs.vh"
module tb_top;
   reg clk_in = 1'b0;
   reg rst_n_in = 1'b0;
   reg internal_fault_in = 1'b0;
   reg [2:0] temp_valid_in = 3'h0;
   reg [2:0] sensor_fault_in = 3'h0;
   reg [23:0] temp_in = 24'h000000;
   wire alarm_relay_closed_out, error_relay_closed_out, led_green_out, led_red_out, motor_power;
   wire [4:0] state_out;
   wire [4:0] outs = {motor_power, alarm_relay_closed_out, error_relay_closed_out, led_green_out, led_red_out};
   // rows: {ch2, ch1, ch0, fault[2:0], state[4:0]}, first row at the top
   localparam [351:0] ROWS = {32'h19191902, 32'h1E1E5F04, 32'h1E641E04, 32'h591E1E02, 32'h00007908,
      32'h00005508, 32'h00005008, 32'h00004F02, 32'h00007804, 32'h00000048, 32'h00000002};
   integer n_mismatch = 0;
   integer cmp_count = 0;
   integer cyc = 0;
   integer i;
   reg [31:0] r;
   reg [3:0] e;
   always #4 clk_in = ~clk_in;
   mom_monitor mom_monitor_i (.*);
   mom_drive_model mom_drive_model_i (.clk_in(clk_in), .error_relay_in(error_relay_closed_out),
      .motor_power_out(motor_power));
   task chk(input [4:0] seen, input [4:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp)
         begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t saw %h want %h", $time, seen, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // strobe readings, then let the two-edge answer settle
   task step(input [23:0] t, input [2:0] v, input [2:0] f);
      begin
         @(posedge clk_in);
         temp_in <= t;
         temp_valid_in <= v;
         sensor_fault_in <= f;
         @(posedge clk_in);
         temp_valid_in <= 3'h0;
         repeat (3) @(posedge clk_in);
         #1;
      end
   endtask
   always @(posedge clk_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 200)
      begin
         n_mismatch = n_mismatch + 1;
         give_verdict;
      end
   end
   initial
   begin
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      for (i = 0; i < 11; i = i + 1)
      begin
         r = ROWS[(10 - i) * 32 +: 32];
         e = (r[4:0] == `MOM_S_NORM) ? 4'hE : (r[4:0] == `MOM_S_ALRM) ? 4'h7 : 4'h1;
         step(r[31:8], 3'h7, r[7:5]);
         chk(state_out, r[4:0]);
         chk(outs, {e[2], e});
      end
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      #1;
      chk(state_out, `MOM_S_INIT);
      chk(outs, 5'h00);
      step(24'h191919, 3'h3, 3'h0);
      chk(state_out, `MOM_S_INIT);
      chk(outs, 5'h00);
      @(posedge clk_in);
      internal_fault_in <= 1'b1;
      step(24'h191919, 3'h7, 3'h0);
      chk(state_out, `MOM_S_DEAD);
      chk(outs, 5'h00);
      give_verdict;
   end
endmodule // tb_top
